// file: verilog/lineiface_dev.sv
// Device end of the host port: serial, strobe and direction-select access.
// Assumes the register store answers reg_rdata in the cycle of reg_re.
`timescale 1ns/1ps
`default_nettype none

module lineiface_dev (
	input wire logic clock,
	input wire logic nrst,
	lineiface_if.dev pins,
	input wire lineiface_pkg::op_mode_t mode,
	input wire logic muxed,
	output logic [lineiface_pkg::ADDR_W-1:0] reg_addr,
	output logic [lineiface_pkg::DATA_W-1:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [lineiface_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [lineiface_pkg::EVENT_N-1:0] event_set,
	input wire logic [lineiface_pkg::EVENT_N-1:0] event_clear,
	input wire logic [lineiface_pkg::EVENT_N-1:0] event_mask,
	output logic [lineiface_pkg::SHAPE_W-1:0] shape_code
);
	import lineiface_pkg::*;

	typedef enum logic [1:0] {
		P_IDLE = 2'h0,
		P_RD = 2'h1,
		P_WR = 2'h3
	} par_state_t;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [SYNC_W-1:0] sync3_r;

	// Two-stage sampler plus one stage for edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else begin
			sync1_r <= {pins.shape_sel_msb, pins.shape_sel_mid, pins.shape_sel_lsb,
				pins.out_edge_select, pins.ad, pins.addr_bus};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	logic msb_rise;
	logic msb_fall;
	logic mid_rise;
	logic mid_fall;
	logic lsb_rise;
	logic lsb_fall;
	logic [DATA_W-1:0] ad_s;
	logic [ADDR_W-1:0] abus_s;

	// Edges of the shared control pins
	assign msb_rise = rose(sync3_r[SY_MSB], sync2_r[SY_MSB]);
	assign msb_fall = fell(sync3_r[SY_MSB], sync2_r[SY_MSB]);
	assign mid_rise = rose(sync3_r[SY_MID], sync2_r[SY_MID]);
	assign mid_fall = fell(sync3_r[SY_MID], sync2_r[SY_MID]);
	assign lsb_rise = rose(sync3_r[SY_LSB], sync2_r[SY_LSB]);
	assign lsb_fall = fell(sync3_r[SY_LSB], sync2_r[SY_LSB]);
	assign ad_s = sync2_r[SY_AD_LSB +: DATA_W];
	assign abus_s = sync2_r[SY_A_LSB +: ADDR_W];

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic is_serial;
	logic is_strobe;
	logic is_dir;
	logic is_par;

	assign is_serial = (mode == MODE_SERIAL);
	assign is_strobe = (mode == MODE_STROBE);
	assign is_dir = (mode == MODE_DIRSEL);
	assign is_par = is_strobe || is_dir;

	// Template code straight from the three pins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shape_code <= '0;
		end else if (mode == MODE_HW) begin
			shape_code <= {sync2_r[SY_MSB], sync2_r[SY_MID], sync2_r[SY_LSB]};
		end
	end

	// ----------------------------------------------------------------
	// Serial shifter
	// ----------------------------------------------------------------
	logic [3:0] ser_cnt_r;
	logic [6:0] ser_shift_r;
	logic ser_read_r;
	logic [3:0] out_idx_r;
	logic sdo_r;
	logic sdo_oe_r;
	logic sclk_rise;
	logic sclk_fall;
	logic out_edge;
	logic cmd_done;
	logic frame_done;
	logic [DATA_W-1:0] ser_byte;
	logic [DATA_W-1:0] rdata_r; // Read data for the bus or the shifter

	assign sclk_rise = is_serial && msb_rise;
	assign sclk_fall = is_serial && msb_fall;
	assign out_edge = sync2_r[SY_EDGE] ? sclk_fall : sclk_rise;
	assign cmd_done = sclk_rise && (ser_cnt_r == SER_CMD_LAST);
	assign frame_done = sclk_rise && (ser_cnt_r == SER_LAST);
	assign ser_byte = {ser_shift_r, sync2_r[SY_LSB]};

	// Input bits on every rising shift clock edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ser_cnt_r <= 4'h0;
			ser_shift_r <= 7'h00;
		end else if (!is_serial) begin
			ser_cnt_r <= 4'h0;
		end else if (sclk_rise) begin
			ser_shift_r <= ser_byte[6:0];
			ser_cnt_r <= ser_cnt_r + 4'h1;
		end
	end

	// Direction of the frame from the command byte
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ser_read_r <= 1'h0;
		end else if (cmd_done) begin
			ser_read_r <= ser_byte[CMD_READ_BIT];
		end
	end

	// Output driver: released for writes and during the command byte
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sdo_r <= 1'h0;
			sdo_oe_r <= 1'h0;
			out_idx_r <= 4'h0;
		end else if (!is_serial) begin
			sdo_oe_r <= 1'h0;
			out_idx_r <= 4'h0;
		end else if (sclk_fall && out_idx_r == SER_DATA_BITS) begin
			sdo_oe_r <= 1'h0;
			out_idx_r <= 4'h0;
		end else if (out_edge && ser_read_r && ser_cnt_r[3] && !out_idx_r[3]) begin
			sdo_r <= rdata_r[~out_idx_r[2:0]];
			sdo_oe_r <= 1'h1;
			out_idx_r <= out_idx_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Parallel strobes
	// ----------------------------------------------------------------
	logic start_rd;
	logic start_wr;
	logic end_rd;
	logic end_wr;
	par_state_t par_state_r;
	logic hs_r;
	logic bus_oe_r;
	logic rd_req_r;
	logic wr_req_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;

	// Read strobe and write strobe, or data strobe qualified by direction
	assign start_rd = is_strobe ? mid_fall : (is_dir && lsb_fall && sync2_r[SY_MID]);
	assign start_wr = is_strobe ? lsb_fall : (is_dir && lsb_fall && !sync2_r[SY_MID]);
	assign end_rd = is_strobe ? mid_rise : (is_dir && lsb_rise);
	assign end_wr = is_strobe ? lsb_rise : (is_dir && lsb_rise);

	// Address from the serial command byte, the shared bus or the address pins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			addr_r <= ADDR_RST;
		end else if (cmd_done) begin
			addr_r <= ser_byte[ADDR_W-1:0];
		end else if (is_par && muxed && msb_fall) begin
			addr_r <= ad_s[ADDR_W-1:0];
		end else if (is_par && !muxed && par_state_r == P_IDLE && (start_rd || start_wr)) begin
			addr_r <= abus_s;
		end
	end

	// Bus cycle tracking with ready or acknowledge handshake
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			par_state_r <= P_IDLE;
			hs_r <= 1'h0;
			bus_oe_r <= 1'h0;
		end else if (!is_par) begin
			par_state_r <= P_IDLE;
			hs_r <= 1'h0;
			bus_oe_r <= 1'h0;
		end else begin
			unique case (par_state_r)
				P_IDLE: begin
					if (start_rd) begin
						par_state_r <= P_RD;
					end else if (start_wr) begin
						par_state_r <= P_WR;
						hs_r <= 1'h1;
					end
				end
				P_RD: begin
					if (end_rd) begin
						par_state_r <= P_IDLE;
						hs_r <= 1'h0;
						bus_oe_r <= 1'h0;
					end else if (rd_req_r) begin
						hs_r <= 1'h1;
						bus_oe_r <= 1'h1;
					end
				end
				P_WR: begin
					if (end_wr) begin
						par_state_r <= P_IDLE;
						hs_r <= 1'h0;
					end
				end
			endcase
		end
	end

	// Request pulses toward the register store
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_req_r <= 1'h0;
			wr_req_r <= 1'h0;
		end else begin
			rd_req_r <= (cmd_done && ser_byte[CMD_READ_BIT])
				|| (is_par && par_state_r == P_IDLE && start_rd);
			wr_req_r <= (frame_done && !ser_read_r)
				|| (is_par && par_state_r == P_WR && end_wr);
		end
	end

	// Write data from the serial frame or the bus at strobe rise
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wdata_r <= DATA_RST;
		end else if (frame_done && !ser_read_r) begin
			wdata_r <= ser_byte;
		end else if (is_par && par_state_r == P_WR && end_wr) begin
			wdata_r <= ad_s;
		end
	end

	// Read data held for the bus or the shifter
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= DATA_RST;
		end else if (rd_req_r) begin
			rdata_r <= reg_rdata;
		end
	end

	assign reg_addr = addr_r;
	assign reg_wdata = wdata_r;
	assign reg_we = wr_req_r;
	assign reg_re = rd_req_r;
	assign pins.dev_ad_o = rdata_r;
	assign pins.dev_ad_oe = bus_oe_r;

	// Shared output pin: serial data, ready, or acknowledge
	always_comb begin
		unique case (mode)
			MODE_SERIAL: begin
				pins.serial_out_o = sdo_r;
				pins.serial_out_oe = sdo_oe_r;
			end
			MODE_STROBE: begin
				pins.serial_out_o = hs_r;
				pins.serial_out_oe = 1'h1;
			end
			MODE_DIRSEL: begin
				pins.serial_out_o = !hs_r;
				pins.serial_out_oe = 1'h1;
			end
			MODE_HW: begin
				pins.serial_out_o = 1'h1;
				pins.serial_out_oe = 1'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Attention output
	// ----------------------------------------------------------------
	logic [EVENT_N-1:0] pend_r;
	logic attn_oe_r;

	// Sticky events, a new event beats its clear
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pend_r <= EVENT_RST;
		end else begin
			pend_r <= (pend_r & ~event_clear) | event_set;
		end
	end

	// Pull low while any unmasked event is pending
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			attn_oe_r <= 1'h0;
		end else begin
			attn_oe_r <= |(pend_r & ~event_mask);
		end
	end

	assign pins.attn_o = 1'h0;
	assign pins.attn_oe = attn_oe_r;
endmodule : lineiface_dev
`default_nettype wire

// file: verilog/lineiface_pkg.sv
// Shared constants, mode encoding and edge helpers of the host port.
// Assumes one system clock on both ends and pins sampled by that clock.
package lineiface_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int EVENT_N = 4;
	localparam int SHAPE_W = 3;

	// ----------------------------------------------------------------
	// Pin sharing modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_HW = 2'h0,
		MODE_SERIAL = 2'h1,
		MODE_STROBE = 2'h3,
		MODE_DIRSEL = 2'h2
	} op_mode_t;

	// ----------------------------------------------------------------
	// Serial frame layout: command byte then data byte, MSB first
	// ----------------------------------------------------------------
	localparam int CMD_READ_BIT = 7;
	localparam logic [3:0] SER_CMD_LAST = 4'h7;
	localparam logic [3:0] SER_LAST = 4'hF;
	localparam logic [3:0] SER_DATA_BITS = 4'h8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
	localparam logic [EVENT_N-1:0] EVENT_RST = 4'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS = 80;
	localparam int STEP_NS = 80;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
	localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);

	// ----------------------------------------------------------------
	// Device sampler bit positions
	// ----------------------------------------------------------------
	localparam int SYNC_W = 4 + DATA_W + ADDR_W;
	localparam int SY_MSB = 16;
	localparam int SY_MID = 15;
	localparam int SY_LSB = 14;
	localparam int SY_EDGE = 13;
	localparam int SY_AD_LSB = 5;
	localparam int SY_A_LSB = 0;

	// Edge detection on sampled levels
	function automatic logic rose(input logic prev, input logic cur);
		rose = !prev && cur;
	endfunction : rose

	function automatic logic fell(input logic prev, input logic cur);
		fell = prev && !cur;
	endfunction : fell

endpackage : lineiface_pkg

// file: verilog/lineiface_if.sv
// Pin bundle between the line interface port and its host.
// Assumes pull-ups on the shared bus, the shared output and attention.
`timescale 1ns/1ps
`default_nettype none
interface lineiface_if;
	import lineiface_pkg::*;

	// ----------------------------------------------------------------
	// Host driven pins
	// ----------------------------------------------------------------
	logic shape_sel_msb; // Shift clock, address latch or address strobe
	logic shape_sel_mid; // Read strobe or direction select
	logic shape_sel_lsb; // Serial input, write strobe or data strobe
	logic out_edge_select;
	logic [ADDR_W-1:0] addr_bus;
	logic [DATA_W-1:0] host_ad_o;
	logic host_ad_oe;

	// ----------------------------------------------------------------
	// Device driven pins
	// ----------------------------------------------------------------
	logic serial_out_o; // Serial data, ready or acknowledge
	logic serial_out_oe;
	logic [DATA_W-1:0] dev_ad_o;
	logic dev_ad_oe;
	logic attn_o;
	logic attn_oe;

	// ----------------------------------------------------------------
	// Resolved wire levels
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] ad;
	logic serial_out;
	logic attn_n;

	// Drivers win over the pull-ups
	assign ad = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 8'hFF);
	assign serial_out = serial_out_oe ? serial_out_o : 1'h1;
	assign attn_n = attn_oe ? attn_o : 1'h1;

	modport dev (
		input shape_sel_msb,
		input shape_sel_mid,
		input shape_sel_lsb,
		input out_edge_select,
		input addr_bus,
		input ad,
		output serial_out_o,
		output serial_out_oe,
		output dev_ad_o,
		output dev_ad_oe,
		output attn_o,
		output attn_oe
	);

	modport host (
		output shape_sel_msb,
		output shape_sel_mid,
		output shape_sel_lsb,
		output out_edge_select,
		output addr_bus,
		output host_ad_o,
		output host_ad_oe,
		input ad,
		input serial_out,
		input attn_n
	);
endinterface : lineiface_if
`default_nettype wire

// file: verilog/lineiface_host.sv
// Host end: runs one register access at a time over the shared pins.
// Assumes the device end samples the pins with the same clock.
`timescale 1ns/1ps
`default_nettype none
module lineiface_host (
	input wire logic clock,
	input wire logic nrst,
	lineiface_if.host pins,
	input wire lineiface_pkg::op_mode_t mode,
	input wire logic muxed,
	input wire logic edge_sel_cfg,
	input wire logic [lineiface_pkg::SHAPE_W-1:0] shape_code,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [lineiface_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [lineiface_pkg::DATA_W-1:0] cmd_wdata,
	output logic done,
	output logic [lineiface_pkg::DATA_W-1:0] rdata,
	output logic attn_pending
);
	import lineiface_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_ADDR = 3'h1,
		H_LATCH = 3'h3,
		H_STRB = 3'h2,
		H_HOLD = 3'h6,
		H_SHIFT = 3'h4
	} host_state_t;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic [DATA_W+1:0] sync1_r;
	logic [DATA_W+1:0] sync2_r;
	logic sy_sdo;
	logic [DATA_W-1:0] sy_ad;
	logic hs_ok;
	logic is_strobe;
	logic is_serial;

	// Two-stage sampler for device driven pins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {pins.serial_out, pins.attn_n, pins.ad};
			sync2_r <= sync1_r;
		end
	end

	assign sy_sdo = sync2_r[DATA_W+1];
	assign attn_pending = !sync2_r[DATA_W];
	assign sy_ad = sync2_r[DATA_W-1:0];
	assign is_strobe = (mode == MODE_STROBE);
	assign is_serial = (mode == MODE_SERIAL);
	assign hs_ok = is_strobe ? sy_sdo : !sy_sdo;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	host_state_t st_r;
	logic [3:0] tmr_r;
	logic write_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;
	logic [15:0] tx_r;
	logic [DATA_W-1:0] rx_r;
	logic [3:0] bit_r;
	logic hi_r;
	logic tick;
	logic hold_end;
	logic sample;

	assign cmd_ready = (st_r == H_IDLE) && (mode != MODE_HW);
	assign tick = (tmr_r == ((st_r == H_SHIFT) ? HALF_LAST : STEP_LAST));
	assign hold_end = (st_r == H_HOLD) && tick && (is_serial || !hs_ok);
	assign sample = (st_r == H_SHIFT) && tick && bit_r[3] && (hi_r != edge_sel_cfg);

	// Access phases, shift clock halves and bit count
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_r <= H_IDLE;
			tmr_r <= 4'h0;
			bit_r <= 4'h0;
			hi_r <= 1'h0;
		end else begin
			tmr_r <= tick ? tmr_r : tmr_r + 4'h1;
			unique case (st_r)
				H_IDLE: begin
					tmr_r <= 4'h0;
					bit_r <= 4'h0;
					hi_r <= 1'h0;
					if (cmd_valid && cmd_ready) begin
						st_r <= is_serial ? H_SHIFT : H_ADDR;
					end
				end
				H_ADDR: begin
					if (tick) begin
						st_r <= H_LATCH;
						tmr_r <= 4'h0;
					end
				end
				H_LATCH: begin
					if (tick) begin
						st_r <= H_STRB;
						tmr_r <= 4'h0;
					end
				end
				H_STRB: begin
					if (hs_ok) begin
						st_r <= H_HOLD;
						tmr_r <= 4'h0;
					end
				end
				H_HOLD: begin
					if (hold_end) begin
						st_r <= H_IDLE;
					end
				end
				H_SHIFT: begin
					if (tick) begin
						tmr_r <= 4'h0;
						hi_r <= !hi_r;
						if (hi_r) begin
							bit_r <= bit_r + 4'h1;
							st_r <= (bit_r == SER_LAST) ? H_HOLD : H_SHIFT;
						end
					end
				end
			endcase
		end
	end

	// Command capture and serial shift registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			write_r <= 1'h0;
			addr_r <= ADDR_RST;
			wdata_r <= DATA_RST;
			tx_r <= 16'h0000;
			rx_r <= DATA_RST;
		end else if (st_r == H_IDLE && cmd_valid && cmd_ready) begin
			write_r <= cmd_write;
			addr_r <= cmd_addr;
			wdata_r <= cmd_wdata;
			tx_r <= {!cmd_write, 2'h0, cmd_addr, cmd_wdata};
		end else begin
			if (st_r == H_SHIFT && tick && hi_r) begin
				tx_r <= {tx_r[14:0], 1'h0};
			end
			if (sample) begin
				rx_r <= {rx_r[6:0], sy_sdo};
			end
		end
	end

	// Read data and completion pulse
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata <= DATA_RST;
			done <= 1'h0;
		end else begin
			done <= hold_end;
			if (st_r == H_STRB && hs_ok && !write_r) begin
				rdata <= sy_ad;
			end else if (hold_end && is_serial && !write_r) begin
				rdata <= rx_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers, registered from the phase
	// ----------------------------------------------------------------
	logic strb_ph;
	logic addr_ph;

	assign strb_ph = (st_r == H_STRB);
	assign addr_ph = (st_r == H_ADDR) || (st_r == H_LATCH);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pins.shape_sel_msb <= 1'h0;
			pins.shape_sel_mid <= 1'h1;
			pins.shape_sel_lsb <= 1'h1;
		end else begin
			unique case (mode)
				MODE_HW: begin
					{pins.shape_sel_msb, pins.shape_sel_mid, pins.shape_sel_lsb} <= shape_code;
				end
				MODE_SERIAL: begin
					pins.shape_sel_msb <= hi_r && (st_r == H_SHIFT);
					pins.shape_sel_mid <= 1'h0;
					pins.shape_sel_lsb <= tx_r[15];
				end
				MODE_STROBE: begin
					pins.shape_sel_msb <= muxed ? (st_r == H_ADDR) : 1'h1;
					pins.shape_sel_mid <= !(strb_ph && !write_r);
					pins.shape_sel_lsb <= !(strb_ph && write_r);
				end
				MODE_DIRSEL: begin
					pins.shape_sel_msb <= muxed ? !((st_r == H_LATCH) || strb_ph) : 1'h1;
					pins.shape_sel_mid <= (st_r == H_IDLE) ? 1'h1 : !write_r;
					pins.shape_sel_lsb <= !strb_ph;
				end
			endcase
		end
	end

	// Shared bus, address pins and edge select
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pins.host_ad_o <= DATA_RST;
			pins.host_ad_oe <= 1'h0;
			pins.addr_bus <= ADDR_RST;
			pins.out_edge_select <= 1'h0;
		end else begin
			pins.out_edge_select <= edge_sel_cfg;
			pins.addr_bus <= (st_r == H_IDLE) ? ADDR_RST : addr_r;
			if (is_serial) begin
				pins.host_ad_o <= DATA_RST;
				pins.host_ad_oe <= 1'h1;
			end else if (mode != MODE_HW && muxed && addr_ph) begin
				pins.host_ad_o <= {3'h0, addr_r};
				pins.host_ad_oe <= 1'h1;
			end else if (mode != MODE_HW && write_r && (strb_ph || st_r == H_HOLD)) begin
				pins.host_ad_o <= wdata_r;
				pins.host_ad_oe <= 1'h1;
			end else begin
				pins.host_ad_oe <= 1'h0;
			end
		end
	end
endmodule : lineiface_host
`default_nettype wire

// file: tb/lineiface_properties.sv
// Pin checker of the host port.
// Assumes the bench wires it to the pin bundle.
`timescale 1ns/1ps
`default_nettype none
module lineiface_properties (
	input wire logic clock,
	input wire logic nrst,
	input wire lineiface_pkg::op_mode_t mode,
	input wire logic shape_sel_msb,
	input wire logic shape_sel_mid,
	input wire logic shape_sel_lsb,
	input wire logic out_edge_select,
	input wire logic serial_out_o,
	input wire logic serial_out_oe,
	input wire logic dev_ad_oe,
	input wire logic attn_o,
	input wire logic attn_oe
);
	import lineiface_pkg::*;
	logic msb_r;
	logic rd_r;
	logic rise;
	logic [3:0] cnt_r;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Shift clock rise detect
	assign rise = mode == MODE_SERIAL && shape_sel_msb && !msb_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) msb_r <= 1'h0;
		else msb_r <= shape_sel_msb;
	end
	// Bit position in the frame
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) cnt_r <= 4'h0;
		else if (mode != MODE_SERIAL) cnt_r <= 4'h0;
		else if (rise) cnt_r <= cnt_r + 4'h1;
	end
	// Read flag of the frame
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) rd_r <= 1'h0;
		else if (rise && cnt_r == 4'h0) rd_r <= shape_sel_lsb;
	end
	sequence s_ack_read;
		##[2:10] (!serial_out_o && dev_ad_oe);
	endsequence
	a_cmd_quiet: assert property (mode == MODE_SERIAL && cnt_r inside {[4'h1:4'h7]} |-> !serial_out_oe)
		else $error("serial output driven in command byte");
	a_write_quiet: assert property (mode == MODE_SERIAL && !rd_r && cnt_r != 4'h0 |-> !serial_out_oe)
		else $error("serial output driven in write frame");
	a_read_driven: assert property (mode == MODE_SERIAL && rd_r && cnt_r == 4'hC |-> serial_out_oe)
		else $error("serial read data not driven");
	a_out_edge: assert property (mode == MODE_SERIAL && serial_out_oe && $past(serial_out_oe)
		&& $changed(serial_out_o) |-> shape_sel_msb != out_edge_select)
		else $error("serial output moved on wrong edge");
	a_ready_read: assert property (mode == MODE_STROBE && $fell(shape_sel_mid)
		|-> ##[2:10] (serial_out_o && dev_ad_oe))
		else $error("no ready on read");
	a_ready_write: assert property (mode == MODE_STROBE && $fell(shape_sel_lsb) |-> ##[2:10] serial_out_o)
		else $error("no ready on write");
	a_ready_drop: assert property (mode == MODE_STROBE && $rose(shape_sel_lsb) |-> ##[1:8] !serial_out_o)
		else $error("ready held after strobe");
	a_ack_read: assert property (mode == MODE_DIRSEL && shape_sel_mid && $fell(shape_sel_lsb) |-> s_ack_read)
		else $error("no acknowledge on read");
	a_ack_write: assert property (mode == MODE_DIRSEL && !shape_sel_mid && $fell(shape_sel_lsb)
		|-> ##[2:10] (!serial_out_o && !dev_ad_oe))
		else $error("no acknowledge on write");
	a_bus_dir: assert property (mode == MODE_DIRSEL && dev_ad_oe |-> shape_sel_mid)
		else $error("bus driven in write");
	a_attn_drain: assert property (attn_oe |-> !attn_o)
		else $error("attention driven high");
endmodule : lineiface_properties
`default_nettype wire

// file: tb/lineiface_host_port_tb_top.sv
// Bench joining host and device ends.
// Assumes both ends share the bench clock.
`timescale 1ns/1ps
`default_nettype none
module lineiface_host_port_tb_top;
	import lineiface_pkg::*;
	logic clock, nrst, muxed, edge_sel, cmd_valid, cmd_ready, cmd_write, done, attn_pending, reg_we;
	op_mode_t mode;
	logic [4:0] cmd_addr, reg_addr;
	logic [7:0] cmd_wdata, rdata, reg_wdata, we_cnt;
	logic [3:0] ev_set, ev_clr, ev_mask;
	logic [2:0] hw_code, dev_code;
	int err_count, num_checks;
	lineiface_if bus_if();
	lineiface_host lineiface_host_inst (.clock(clock), .nrst(nrst), .pins(bus_if), .mode(mode),
		.muxed(muxed), .edge_sel_cfg(edge_sel), .shape_code(hw_code), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.done(done), .rdata(rdata), .attn_pending(attn_pending));
	lineiface_dev lineiface_dev_inst (.clock(clock), .nrst(nrst), .pins(bus_if), .mode(mode),
		.muxed(muxed), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(),
		.reg_rdata({~reg_addr[2:0], reg_addr}), .event_set(ev_set), .event_clear(ev_clr),
		.event_mask(ev_mask), .shape_code(dev_code));
	lineiface_properties lineiface_properties_inst (.clock(clock), .nrst(nrst), .mode(mode),
		.shape_sel_msb(bus_if.shape_sel_msb), .shape_sel_mid(bus_if.shape_sel_mid),
		.shape_sel_lsb(bus_if.shape_sel_lsb), .out_edge_select(bus_if.out_edge_select),
		.serial_out_o(bus_if.serial_out_o), .serial_out_oe(bus_if.serial_out_oe),
		.dev_ad_oe(bus_if.dev_ad_oe), .attn_o(bus_if.attn_o), .attn_oe(bus_if.attn_oe));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Count register writes
	always @(posedge clock or negedge nrst) begin
		if (!nrst) we_cnt <= 8'h00;
		else if (reg_we === 1'b1) we_cnt <= we_cnt + 8'h01;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	// One access through the host end
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(negedge clock);
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(posedge clock);
		cmd_valid <= 1'b0;
		while (done !== 1'b1) @(negedge clock);
		@(posedge clock);
	endtask : acc
	initial begin
		#200us;
		err_count++;
		end_of_test();
	end
	initial begin
		logic [4:0] a;
		nrst = 1'b0;
		mode = MODE_SERIAL;
		{muxed, edge_sel, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
		{hw_code, ev_set, ev_clr, ev_mask} = '0;
		wt(2);
		nrst <= 1'b1;
		wt(4);
		// Write then read the same address in each access mode
		for (int i = 0; i < 6; i++) begin
			a = i[0] ? 5'h1F : 5'(i);
			mode <= i < 2 ? MODE_SERIAL : (i < 4 ? MODE_STROBE : MODE_DIRSEL);
			muxed <= i[0];
			edge_sel <= i[0];
			wt(10);
			acc(1'b1, a, 8'hC3 ^ 8'(i));
			chk({3'h0, reg_addr}, {3'h0, a});
			chk(reg_wdata, 8'hC3 ^ 8'(i));
			chk(we_cnt, 8'(i + 1));
			acc(1'b0, a, 8'h00);
			chk(rdata, {~a[2:0], a});
		end
		// Template code in hardware mode
		mode <= MODE_HW;
		for (int k = 0; k < 8; k++) begin
			hw_code <= 3'(k);
			wt(8);
			chk({5'h0, dev_code}, 8'(k));
		end
		// Each event source raised, masked, cleared
		for (int j = 0; j < 4; j++) begin
			ev_set <= 4'(1 << j);
			wt(1);
			ev_set <= 4'h0;
			wt(8);
			chk(8'(attn_pending), 8'h01);
			ev_mask <= 4'(1 << j);
			wt(8);
			chk(8'(attn_pending), 8'h00);
			ev_mask <= 4'h0;
			ev_clr <= 4'(1 << j);
			wt(1);
			ev_clr <= 4'h0;
			wt(8);
			chk(8'(attn_pending), 8'h00);
		end
		end_of_test();
	end
endmodule : lineiface_host_port_tb_top
`default_nettype wire
